// [include/sar_adc_pkg.sv]
/*
  Shared constants of the converter control block: register offsets,
  field positions, reset values, conversion timing and power states.
  Assumes a 32-bit APB register bus and one system clock.
*/
package sar_adc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [11:0] OFS_RESULT_HIGH  = 12'h000;
  localparam logic [11:0] OFS_RESULT_LOW   = 12'h004;
  localparam logic [11:0] OFS_SETUP        = 12'h008;
  localparam logic [11:0] OFS_TRIGGER      = 12'h00c;

  // ---------------------------------------------------------------
  // Field positions and fixed bits
  // ---------------------------------------------------------------
  localparam int         RES_BITS         = 10;
  localparam int         BIT_TIME_SEL     = 7;
  localparam int         BIT_SETUP_RSVD   = 6;
  localparam int         BIT_START_FLAG   = 7;
  localparam logic [7:0] SETUP_ONES_MASK  = 8'h30;
  localparam logic [6:0] TRIGGER_ONES     = 7'h7f;
  localparam logic [3:0] CHANNEL_RESET    = 4'h0;

  // ---------------------------------------------------------------
  // Conversion timing in system clock states
  // ---------------------------------------------------------------
  localparam int CONV_STATES_SLOW = 62;
  localparam int CONV_STATES_FAST = 31;
  localparam int SAMPLE_SLOW_INT  = 2;
  localparam int SAMPLE_FAST_INT  = 1;
  localparam logic [2:0] SAMPLE_SLOW = 3'(SAMPLE_SLOW_INT);
  localparam logic [2:0] SAMPLE_FAST = 3'(SAMPLE_FAST_INT);
  localparam logic [2:0] STEP_SLOW   =
    3'((CONV_STATES_SLOW - SAMPLE_SLOW_INT) / RES_BITS);
  localparam logic [2:0] STEP_FAST   =
    3'((CONV_STATES_FAST - SAMPLE_FAST_INT) / RES_BITS);

  // ---------------------------------------------------------------
  // Chip power states seen by the block
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_ACTIVE     = 3'h0,
    PWR_SLEEP      = 3'h1,
    PWR_WATCH      = 3'h2,
    PWR_SUB_ACTIVE = 3'h3,
    PWR_SUB_SLEEP  = 3'h4,
    PWR_STANDBY    = 3'h5
  } power_state_e;

endpackage

// [include/sar_if.sv]
/*
  Interface between the register front end and the approximation
  sequencer. Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface sar_if;
  logic                            start;    // Begin a conversion
  logic                            abort;    // Stop at once, no result
  logic                            fast;     // Short conversion time
  logic                            cmp;      // Synchronised comparator
  logic                            busy;     // Conversion running
  logic                            finish;   // Last step this cycle
  logic                            sampling; // Sample phase, registered
  logic [sar_adc_pkg::RES_BITS-1:0] result;  // Stored result
  logic [sar_adc_pkg::RES_BITS-1:0] trial;   // Trial code to the DAC

  modport ctrl   (output start, abort, fast, cmp,
                  input  busy, finish, sampling, result, trial);
  modport engine (input  start, abort, fast, cmp,
                  output busy, finish, sampling, result, trial);
endinterface

// [core/channel_decode.sv]
/*
  Decodes the four-bit channel field into a one-hot input select.
  Assumes the caller registers the output before it leaves the block.
*/
`timescale 1ns/1ns
module channel_decode (
  input  wire logic [3:0] channel_field, // Channel code from setup
  output logic      [3:0] input_onehot   // One-hot analog select
);

  // Codes 00xx pick nothing, 1xxx is prohibited and also picks nothing
  function automatic logic [3:0] decode(input logic [3:0] code);
    logic [3:0] sel;
    sel = 4'h0;
    if (code[3:2] == 2'h1) begin
      sel[code[1:0]] = 1'b1;
    end
    return sel;
  endfunction

  always_comb begin
    input_onehot = decode(channel_field);
  end

endmodule

// [core/sar_sequencer.sv]
/*
  Successive-approximation sequencer: sample phase, then one bit per
  step, result stored on completion. Assumes the comparator input is
  already synchronised and valid two cycles after the trial code moves.
*/
`timescale 1ns/1ns
module sar_sequencer #(
  parameter int RES = 10 // Result width
) (
  input wire logic pclk,    // System clock
  input wire logic presetn, // Asynchronous reset, active low
  sar_if.engine    sar      // Link to the register front end
);

  // Elaboration check: the step counters are sized for the package width
  if (RES != sar_adc_pkg::RES_BITS) begin
    $error("sar_sequencer: RES must equal the package width");
  end

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_SAMPLE  = 2'h1,
    ST_CONVERT = 2'h2
  } seq_state_e;

  seq_state_e     state, next_state;
  logic [2:0]     tick, next_tick;
  logic [3:0]     bit_idx, next_bit_idx;
  logic [RES-1:0] trial, next_trial;
  logic           sampling, next_sampling;
  logic [RES-1:0] result, next_result;
  logic [2:0]     sample_len;
  logic [2:0]     step_len;
  logic           step_end;

  // Step length follows the time select; the tick counts cycles in a step, step_end marks its last one
  always_comb begin
    sample_len = sar.fast ? sar_adc_pkg::SAMPLE_FAST
                          : sar_adc_pkg::SAMPLE_SLOW;
    step_len   = sar.fast ? sar_adc_pkg::STEP_FAST
                          : sar_adc_pkg::STEP_SLOW;
    step_end   = (state == ST_CONVERT) && (tick == step_len - 3'h1);
  end

  // Next state: abort beats everything, including the final step
  always_comb begin
    next_state    = state;
    next_tick     = tick + 3'h1;
    next_bit_idx  = bit_idx;
    next_trial    = trial;
    next_result   = result;
    sar.finish    = 1'b0;
    case (state)
      ST_IDLE: begin
        next_tick = 3'h0;
        if (sar.start) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tick == sample_len - 3'h1) begin
          next_state   = ST_CONVERT;
          next_tick    = 3'h0;
          next_bit_idx = 4'(RES - 1);
          next_trial   = {1'b1, {(RES-1){1'b0}}};
        end
      end
      ST_CONVERT: begin
        if (step_end) begin
          next_tick = 3'h0;
          // Keep the trial bit only if the input stands above it
          next_trial[bit_idx] = sar.cmp;
          if (bit_idx == 4'h0) begin
            next_state  = ST_IDLE;
            next_result = {trial[RES-1:1], sar.cmp};
            sar.finish  = 1'b1;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_trial[bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (sar.abort) begin
      next_state  = ST_IDLE;
      next_tick   = 3'h0;
      next_result = result;
      sar.finish  = 1'b0;
    end
    next_sampling = (next_state == ST_SAMPLE);
  end

  // Control flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      tick     <= 3'h0;
      bit_idx  <= 4'h0;
      trial    <= '0;
      sampling <= 1'b0;
    end else begin
      state    <= next_state;
      tick     <= next_tick;
      bit_idx  <= next_bit_idx;
      trial    <= next_trial;
      sampling <= next_sampling;
    end
  end

  // Result keeps its value through any reset; undefined at power-up
  always_ff @(posedge pclk) begin
    result <= next_result;
  end

  assign sar.busy     = (state != ST_IDLE);
  assign sar.trial    = trial;
  assign sar.sampling = sampling;
  assign sar.result   = result;

endmodule

// [core/sar_adc_control.sv]
/*
  Top of the converter control block: APB register slave, start flag,
  power-state handling, channel select and conversion-end events.
  Assumes an external comparator that reports whether the selected
  analog input stands above the trial code, and an interrupt unit
  outside that keeps the request flag and its enable.
*/
`timescale 1ns/1ns
module sar_adc_control (
  input  wire logic        pclk,                // System clock
  input  wire logic        presetn,             // Async reset, low
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB access phase
  input  wire logic        pwrite,              // APB write
  input  wire logic [11:0] paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  input  wire logic [3:0]  pstrb,               // APB byte strobes
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  input  wire logic [2:0]  power_state,         // Chip power state
  input  wire logic        module_standby,      // Block standby
  input  wire logic        conv_end_irq_enable, // Interrupt enable
  input  wire logic        cmp_above,           // Comparator pin
  output logic      [3:0]  channel_select,      // One-hot input mux
  output logic             sample_hold,         // Sample phase
  output logic      [9:0]  dac_code,            // Trial code
  output logic             conv_end_pulse,      // Request flag set
  output logic             conv_end_irq         // Interrupt request
);

  sar_if sar ();

  // ---------------------------------------------------------------
  // Comparator synchroniser
  // ---------------------------------------------------------------
  logic cmp_meta;
  logic cmp_sync;
  logic next_cmp_meta;
  logic next_cmp_sync;

  // Comparator settles outside our clock, so it passes two flops
  always_comb begin
    next_cmp_meta = cmp_above;
    next_cmp_sync = cmp_meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= next_cmp_meta;
      cmp_sync <= next_cmp_sync;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setup_phase;
  logic wr_access;
  logic hit_high;
  logic hit_low;
  logic hit_setup;
  logic hit_trigger;
  logic hit_any;
  logic wr_setup;
  logic wr_trigger;
  logic low_power;

  // Address decoding, shared by the read mux and the write strobes
  always_comb begin
    hit_high    = 1'b0;
    hit_low     = 1'b0;
    hit_setup   = 1'b0;
    hit_trigger = 1'b0;
    if (paddr == sar_adc_pkg::OFS_RESULT_HIGH) begin
      hit_high = 1'b1;
    end else if (paddr == sar_adc_pkg::OFS_RESULT_LOW) begin
      hit_low = 1'b1;
    end else if (paddr == sar_adc_pkg::OFS_SETUP) begin
      hit_setup = 1'b1;
    end else if (paddr == sar_adc_pkg::OFS_TRIGGER) begin
      hit_trigger = 1'b1;
    end
    hit_any = hit_high | hit_low | hit_setup | hit_trigger;
  end

  // Writes land only at the edge where the access phase completes
  always_comb begin
    setup_phase = psel & ~penable;
    wr_access   = psel & penable & pready & pwrite & pstrb[0];
    wr_setup    = wr_access & hit_setup;
    wr_trigger  = wr_access & hit_trigger;
  end

  // Watch, sub-active, sub-sleep, standby and module standby
  always_comb begin
    low_power = module_standby
              | ((power_state != sar_adc_pkg::PWR_ACTIVE)
               & (power_state != sar_adc_pkg::PWR_SLEEP));
  end

  // ---------------------------------------------------------------
  // Setup and trigger registers
  // ---------------------------------------------------------------
  logic       conv_time_select;
  logic       setup_reserved;
  logic [3:0] channel_field;
  logic       conv_start_flag;
  logic       next_conv_time_select;
  logic       next_setup_reserved;
  logic [3:0] next_channel_field;
  logic       next_conv_start_flag;
  logic       start_req;
  logic       abort_req;

  // Setup is frozen in low power; it is not guarded against writes
  // during a conversion, software must clear the flag first
  always_comb begin
    next_conv_time_select = conv_time_select;
    next_setup_reserved   = setup_reserved;
    next_channel_field    = channel_field;
    if (wr_setup && !low_power) begin
      next_conv_time_select = pwdata[sar_adc_pkg::BIT_TIME_SEL];
      next_setup_reserved   = pwdata[sar_adc_pkg::BIT_SETUP_RSVD];
      next_channel_field    = pwdata[3:0];
    end
  end

  // Start only from idle; a zero write or low power stops a run
  always_comb begin
    start_req = wr_trigger & pwdata[sar_adc_pkg::BIT_START_FLAG]
              & ~conv_start_flag & ~low_power & ~sar.busy;
    abort_req = conv_start_flag
              & ((wr_trigger & ~pwdata[sar_adc_pkg::BIT_START_FLAG])
               | low_power);
  end

  // Flag stays up for the whole run and drops with the result load
  always_comb begin
    next_conv_start_flag = conv_start_flag;
    if (low_power) begin
      next_conv_start_flag = 1'b0;
    end else if (abort_req) begin
      next_conv_start_flag = 1'b0;
    end else if (sar.finish) begin
      next_conv_start_flag = 1'b0;
    end else if (start_req) begin
      next_conv_start_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_time_select <= 1'b0;
      setup_reserved   <= 1'b0;
      channel_field    <= sar_adc_pkg::CHANNEL_RESET;
      conv_start_flag  <= 1'b0;
    end else begin
      conv_time_select <= next_conv_time_select;
      setup_reserved   <= next_setup_reserved;
      channel_field    <= next_channel_field;
      conv_start_flag  <= next_conv_start_flag;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer link
  // ---------------------------------------------------------------
  always_comb begin
    sar.start = start_req;
    sar.abort = abort_req;
    sar.fast  = conv_time_select;
    sar.cmp   = cmp_sync;
  end

  sar_sequencer #(
    .RES (sar_adc_pkg::RES_BITS)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sar     (sar)
  );

  logic [3:0] input_onehot;

  channel_decode u_dec (
    .channel_field (channel_field),
    .input_onehot  (input_onehot)
  );

  assign sample_hold = sar.sampling;
  assign dac_code    = sar.trial;

  // ---------------------------------------------------------------
  // Analog select and conversion-end events
  // ---------------------------------------------------------------
  logic [3:0] next_channel_select;
  logic       next_conv_end_pulse;
  logic       next_conv_end_irq;

  // The event pulses on the same edge that clears the flag
  always_comb begin
    next_channel_select = input_onehot;
    next_conv_end_pulse = sar.finish;
    next_conv_end_irq   = sar.finish & conv_end_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= 4'h0;
      conv_end_pulse <= 1'b0;
      conv_end_irq   <= 1'b0;
    end else begin
      channel_select <= next_channel_select;
      conv_end_pulse <= next_conv_end_pulse;
      conv_end_irq   <= next_conv_end_irq;
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  logic [31:0] read_word;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Read mux; fixed-one bits are forced here, not stored
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_high) begin
      read_word[7:0] = sar.result[9:2];
    end else if (hit_low) begin
      read_word[7:6] = sar.result[1:0];
    end else if (hit_setup) begin
      read_word[7:0] = {conv_time_select, setup_reserved, 2'h0,
                        channel_field} | sar_adc_pkg::SETUP_ONES_MASK;
    end else if (hit_trigger) begin
      read_word[7:0] = {conv_start_flag,
                        sar_adc_pkg::TRIGGER_ONES};
    end
  end

  // Answer is registered in setup, so every access has one wait-free
  // access cycle; unmapped addresses answer with an error
  always_comb begin
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_prdata  = read_word;
      next_pready  = 1'b1;
      next_pslverr = ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// [dv/sar_adc_control_props.sv]
/*
  Port checker of the converter control block.
  Assumes it is bound to the block top and sees only its ports.
*/
`timescale 1ns/1ns
module sar_adc_control_props (
  input wire logic        pclk,                // System clock
  input wire logic        presetn,             // Async reset, low
  input wire logic        pwrite,              // APB write
  input wire logic [11:0] paddr,               // APB address
  input wire logic [31:0] prdata,              // APB read data
  input wire logic        pready,              // APB ready
  input wire logic        pslverr,             // APB error
  input wire logic [2:0]  power_state,         // Chip power state
  input wire logic        module_standby,      // Block standby
  input wire logic        conv_end_irq_enable, // Interrupt enable
  input wire logic [3:0]  channel_select,      // One-hot mux
  input wire logic        sample_hold,         // Sample phase
  input wire logic [9:0]  dac_code,            // Trial code
  input wire logic        conv_end_pulse,      // End event
  input wire logic        conv_end_irq         // Interrupt request
);
  // ----------------------------------------------------------
  // Helper: cycles since the sample phase began
  // ----------------------------------------------------------
  logic [7:0] cnt;
  logic       sh_q;
  logic       lp;
  logic       rd_ok;
  // Saturates so a long idle never wraps into a legal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      sh_q <= 1'b0;
    end else begin
      sh_q <= sample_hold;
      if (sample_hold && !sh_q) begin
        cnt <= 8'h01;
      end else if (cnt != 8'h00 && cnt != 8'hff) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  // Low power as the block sees it, and a good read answer
  assign lp = module_standby || (power_state > 3'h1);
  assign rd_ok = pready && !pslverr && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_end_time;
    conv_end_pulse |-> (cnt == 8'h3e || cnt == 8'h1f);
  endproperty
  a_end_time: assert property (p_end_time)
    else $error("end pulse at wrong time");
  property p_end_single;
    conv_end_pulse |=> !conv_end_pulse;
  endproperty
  a_end_single: assert property (p_end_single)
    else $error("end pulse longer than one cycle");
  property p_irq_needs_end;
    conv_end_irq |-> conv_end_pulse;
  endproperty
  a_irq_needs_end: assert property (p_irq_needs_end)
    else $error("interrupt without end pulse");
  property p_irq_gate;
    conv_end_pulse |-> conv_end_irq == $past(conv_end_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt does not follow enable");
  property p_onehot;
    $onehot0(channel_select);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one input selected");
  property p_first_trial;
    $fell(sample_hold) && !lp |-> ##[0:1] dac_code == 10'h200;
  endproperty
  a_first_trial: assert property (p_first_trial)
    else $error("first trial is not the top bit");
  property p_lp_quiet;
    lp && $past(lp) |-> !conv_end_pulse;
  endproperty
  a_lp_quiet: assert property (p_lp_quiet)
    else $error("end pulse in low power");
  property p_trig_ones;
    rd_ok && paddr == sar_adc_pkg::OFS_TRIGGER |-> prdata[6:0] == 7'h7f;
  endproperty
  a_trig_ones: assert property (p_trig_ones)
    else $error("trigger low bits not one");
  property p_setup_ones;
    rd_ok && paddr == sar_adc_pkg::OFS_SETUP |-> prdata[5:4] == 2'b11;
  endproperty
  a_setup_ones: assert property (p_setup_ones)
    else $error("setup fixed bits not one");
endmodule

bind sar_adc_control sar_adc_control_props i_props (
  .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_state(power_state), .module_standby(module_standby),
  .conv_end_irq_enable(conv_end_irq_enable),
  .channel_select(channel_select), .sample_hold(sample_hold),
  .dac_code(dac_code), .conv_end_pulse(conv_end_pulse),
  .conv_end_irq(conv_end_irq)
);

// [dv/sar_comparator_model.sv]
/*
  Model of the analog mux and comparator at the far side.
  Assumes one fixed level per input, held during the sample phase.
*/
`timescale 1ns/1ns
module sar_comparator_model #(
  parameter logic [9:0] LEVEL_0 = 10'h000, // Input zero level
  parameter logic [9:0] LEVEL_1 = 10'h000, // Input one level
  parameter logic [9:0] LEVEL_2 = 10'h000, // Input two level
  parameter logic [9:0] LEVEL_3 = 10'h000  // Input three level
) (
  input  wire logic       pclk,           // System clock
  input  wire logic [3:0] channel_select, // One-hot mux
  input  wire logic       sample_hold,    // Sample phase
  input  wire logic [9:0] dac_code,       // Trial code
  output logic            cmp_above       // Comparator output
);
  // ----------------------------------------------------------
  // Sample and compare
  // ----------------------------------------------------------
  logic [9:0] lvl;
  logic [9:0] held;
  logic       flip = 1'b0;
  // Mux of the selected input
  always_comb begin
    case (channel_select)
      4'h2: lvl = LEVEL_1;
      4'h4: lvl = LEVEL_2;
      4'h8: lvl = LEVEL_3;
      default: lvl = LEVEL_0;
    endcase
  end
  // Capacitor follows the input only while sampling
  always_ff @(posedge pclk) begin
    flip <= ~flip;
    if (sample_hold) begin
      held <= lvl;
    end
  end
  // Level sits half a step above its code, so equal counts as above;
  // an open mux gives a toggling output rather than a stale one
  assign cmp_above = (channel_select == 4'h0) ? flip : (held >= dac_code);
endmodule

// [dv/sar_adc_control_test.sv]
/*
  Register-level testbench of the converter control block.
  Assumes the comparator model and the bound port checker.
*/
`timescale 1ns/1ns
module sar_adc_control_test;
  // ----------------------------------------------------------
  // Signals and the far side
  // ----------------------------------------------------------
  localparam logic [9:0] LVL [4] = '{10'h2a5, 10'h001, 10'h3fe, 10'h15a};
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, channel_select;
  logic        pready, pslverr, er, module_standby, conv_end_irq_enable;
  logic [2:0]  power_state;
  logic        cmp_above, sample_hold, conv_end_pulse, conv_end_irq;
  logic [9:0]  dac_code;
  int          miscompares, n_tests, n_end, n_irq, cycles;

  sar_adc_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_state(power_state), .module_standby(module_standby),
    .conv_end_irq_enable(conv_end_irq_enable), .cmp_above(cmp_above),
    .channel_select(channel_select), .sample_hold(sample_hold),
    .dac_code(dac_code), .conv_end_pulse(conv_end_pulse),
    .conv_end_irq(conv_end_irq));
  sar_comparator_model #(.LEVEL_0(LVL[0]), .LEVEL_1(LVL[1]),
    .LEVEL_2(LVL[2]), .LEVEL_3(LVL[3])) i_far (.pclk(pclk),
    .channel_select(channel_select), .sample_hold(sample_hold),
    .dac_code(dac_code), .cmp_above(cmp_above));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Event counters and the hang guard; old values seen at the edge
  always @(posedge pclk) begin
    cycles++;
    if (conv_end_pulse === 1'b1) n_end++;
    if (conv_end_irq === 1'b1) n_irq++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is taken at a rising edge; the wait has no limit of its own, only the hang guard ends one that never sees ready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(nm, rd, {24'h000000, exp});
  endtask
  // Polls the start flag; bounded at 40 polls, about twice a slow conversion's length
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      xfer(1'b0, sar_adc_pkg::OFS_TRIGGER, 8'h00);
      k++;
    end while (rd[7] !== 1'b0 && k < 40);
  endtask
  task automatic conv(input int ch, input logic fast, en);
    int e0, i0;
    xfer(1'b1, sar_adc_pkg::OFS_SETUP, {fast, 5'h01, 2'(ch)});
    conv_end_irq_enable <= en;
    e0 = n_end;
    i0 = n_irq;
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h80);
    check("select", {28'h0, channel_select}, 32'h1 << ch);
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h80);
    rdchk("busy", sar_adc_pkg::OFS_TRIGGER, 8'hff);
    wait_idle();
    check("ends", n_end - e0, 32'h1);
    check("irqs", n_irq - i0, {31'h0, en});
    rdchk("high", sar_adc_pkg::OFS_RESULT_HIGH, LVL[ch][9:2]);
    rdchk("low", sar_adc_pkg::OFS_RESULT_LOW, {LVL[ch][1:0], 6'h00});
  endtask
  task automatic complete_run();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    int e0;
    {presetn, psel, penable, pwrite, module_standby} = 5'h00;
    {paddr, pwdata, power_state, conv_end_irq_enable} = '0;
    pstrb = 4'hf;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("setup", sar_adc_pkg::OFS_SETUP, 8'h30);
    rdchk("trig", sar_adc_pkg::OFS_TRIGGER, 8'h7f);
    xfer(1'b0, 12'h010, 8'h00);
    check("unmapped", {31'h0, er}, 32'h1);
    // Every legal channel code; fixed bits written as zero
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, sar_adc_pkg::OFS_SETUP, 8'(c));
      rdchk("setup", sar_adc_pkg::OFS_SETUP, 8'h30 | 8'(c));
      check("sel", {28'h0, channel_select},
            c > 3 ? 32'h1 << (c - 4) : 32'h0);
    end
    for (int ch = 0; ch < 4; ch++) conv(ch, ch[0], ch[1]);
    // Abort in mid-run: no end, results kept
    e0 = n_end;
    xfer(1'b1, sar_adc_pkg::OFS_SETUP, 8'h84);
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h80);
    repeat (10) @(posedge pclk);
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h00);
    rdchk("abort", sar_adc_pkg::OFS_TRIGGER, 8'h7f);
    repeat (80) @(posedge pclk);
    check("no end", n_end - e0, 32'h0);
    rdchk("kept", sar_adc_pkg::OFS_RESULT_HIGH, LVL[3][9:2]);
    // Watch mode mid-run, then module standby
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h80);
    power_state <= 3'(sar_adc_pkg::PWR_WATCH);
    repeat (5) @(posedge pclk);
    rdchk("lp trig", sar_adc_pkg::OFS_TRIGGER, 8'h7f);
    xfer(1'b1, sar_adc_pkg::OFS_SETUP, 8'h05);
    power_state <= 3'(sar_adc_pkg::PWR_ACTIVE);
    rdchk("lp setup", sar_adc_pkg::OFS_SETUP, 8'hb4);
    xfer(1'b1, sar_adc_pkg::OFS_TRIGGER, 8'h80);
    module_standby <= 1'b1;
    rdchk("ms trig", sar_adc_pkg::OFS_TRIGGER, 8'h7f);
    module_standby <= 1'b0;
    repeat (10) @(posedge pclk);
    conv(2, 1'b0, 1'b1);
    // Second reset keeps the result, clears setup
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("rst high", sar_adc_pkg::OFS_RESULT_HIGH, LVL[2][9:2]);
    rdchk("rst low", sar_adc_pkg::OFS_RESULT_LOW, 8'h80);
    rdchk("rst setup", sar_adc_pkg::OFS_SETUP, 8'h30);
    complete_run();
  end
endmodule
